// ---- design/sam_alarm_manager.sv ----
// Contract
// - Detected alarm code shown blinking automatically
// - Only highest priority active alarm shown
// - Fixed rank overcurrent one through amplifier heat
// - Blink toggles about every half second
// - First ten alarms remove drive immediately
// - Last five decelerate max torque, then coast
// - Reset sequence input clears resettable alarms
// - Encoder, power, memory, duplication need power cycle
// - Keypad test clear function clears resettable alarms
// - Transistor overcurrent raises overcurrent alarm
// - Speed above 1.1 times maximum: overspeed
// - DC link above 420 V: overvoltage
// - Encoder self diagnosis fault: encoder trouble
// - Missing encoder serial traffic: link alarm
// - Corrupt parameter memory raises memory alarm
// - Regenerative transistor overheat raises alarm
// - Faulty control supply raises control power alarm
// - Duplicate input assignments, forced stop excepted
// - Position deviation above width: deviation alarm
// - Thermal model torque excess raises overload
// - Undervoltage detected only when setting equals 1
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module sam_alarm_manager #(
	parameter int BLINK_CYCLES = sam_pkg::BLINK_HALF_CYCLES,
	parameter int ENC_LOSS_LIMIT = sam_pkg::ENC_LOSS_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Power stage detections
	input wire logic ocTrip1,
	input wire logic ocTrip2,
	input wire logic [9:0] dcLinkVolts,
	input wire logic ctrlPowerFault,
	input wire logic nvmCorrupt,
	input wire logic regenTrHot,
	input wire logic regenResHot,
	input wire logic ampHot,
	// Motion feedback
	input wire logic [15:0] motorSpeed,
	input wire logic [31:0] cmdPos,
	input wire logic [31:0] fbPos,
	input wire logic [15:0] torqueCmd,
	// Encoder link
	input wire logic encFrameValid,
	input wire logic encDiagFault,
	// Operator inputs
	input wire logic seqResetIn,
	input wire logic kpTestMode,
	input wire logic kpAlarmClearFn,
	// Display and drive outputs
	output logic [3:0] dispCode,
	output logic dispLit,
	output logic driveEnable,
	output logic maxTorqueDecel
);
	import sam_pkg::*;

	// Configuration registers
	// Held in flops only; every setting returns to its default on rstn
	logic [7:0] uvSetting_ff, nxt_uvSetting;
	logic [15:0] maxSpeed_ff, nxt_maxSpeed;
	logic [31:0] devWidth_ff, nxt_devWidth;
	logic [19:0] inAssign_ff, nxt_inAssign;
	logic [15:0] allowTrq_ff, nxt_allowTrq;
	logic [31:0] rdata_ff, nxt_rdata;

	// Detection state
	logic [31:0] encIdle_ff, nxt_encIdle;
	logic [27:0] heat_ff, nxt_heat;
	logic seqReset_ff, nxt_seqReset;
	logic [14:0] alarm_ff, nxt_alarm;
	logic [14:0] detect;
	logic [14:0] dupHit;
	logic clearReq;

	// Display and drive state
	logic [3:0] dispCode_ff, nxt_dispCode;
	logic dispLit_ff, nxt_dispLit;
	sam_drv_t drv_ff, nxt_drv;
	logic [3:0] winCode;
	logic blinkTick;
	logic coastHit;

	// Derived comparisons
	logic [19:0] speedScaled;
	logic [19:0] limitScaled;
	logic [31:0] devAbs;
	logic [15:0] trqAbs;

	// Widen before multiplying; a narrow product would lose its top bits
	assign speedScaled = 20'(motorSpeed) * 20'(OSPD_DEN);
	assign limitScaled = 20'(maxSpeed_ff) * 20'(OSPD_NUM);
	assign devAbs = ($signed(cmdPos) >= $signed(fbPos)) ? cmdPos - fbPos : fbPos - cmdPos;
	assign trqAbs = torqueCmd[15] ? 16'(-torqueCmd) : torqueCmd;

	// Register writes
	// Status and display have no write path, so writes there fall through
	always_comb begin
		nxt_uvSetting = uvSetting_ff;
		nxt_maxSpeed = maxSpeed_ff;
		nxt_devWidth = devWidth_ff;
		nxt_inAssign = inAssign_ff;
		nxt_allowTrq = allowTrq_ff;
		if (regWr) begin
			case (regAddr)
				OFS_CTRL: nxt_uvSetting = regWdata[7:0];
				OFS_MAX_SPEED: nxt_maxSpeed = regWdata[15:0];
				OFS_DEV_WIDTH: nxt_devWidth = regWdata;
				OFS_IN_ASSIGN: nxt_inAssign = regWdata[19:0];
				OFS_ALLOW_TRQ: nxt_allowTrq = regWdata[15:0];
				default: nxt_uvSetting = uvSetting_ff;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe
	// Zero outside the answer cycle keeps an OR-ed read bus clean
	always_comb begin
		nxt_rdata = 32'h0;
		if (regRd) begin
			case (regAddr)
				OFS_CTRL: nxt_rdata = {24'h0, uvSetting_ff};
				OFS_MAX_SPEED: nxt_rdata = {16'h0, maxSpeed_ff};
				OFS_DEV_WIDTH: nxt_rdata = devWidth_ff;
				OFS_IN_ASSIGN: nxt_rdata = {12'h0, inAssign_ff};
				OFS_ALLOW_TRQ: nxt_rdata = {16'h0, allowTrq_ff};
				OFS_STATUS: nxt_rdata = {17'h0, alarm_ff};
				OFS_DISPLAY: nxt_rdata = {24'h0, drv_ff, dispLit_ff, 1'b0, dispCode_ff};
				default: nxt_rdata = 32'h0;
			endcase
		end
	end

	// Register file flops
	// Reset values match the settings of a freshly powered unit
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			uvSetting_ff <= CTRL_RST;
			maxSpeed_ff <= MAX_SPEED_RST;
			devWidth_ff <= DEV_WIDTH_RST;
			inAssign_ff <= IN_ASSIGN_RST;
			allowTrq_ff <= ALLOW_TRQ_RST;
			rdata_ff <= 32'h0;
		end else begin
			uvSetting_ff <= nxt_uvSetting;
			maxSpeed_ff <= nxt_maxSpeed;
			devWidth_ff <= nxt_devWidth;
			inAssign_ff <= nxt_inAssign;
			allowTrq_ff <= nxt_allowTrq;
			rdata_ff <= nxt_rdata;
		end
	end

	// Read port straight from the flop
	assign regRdata = rdata_ff;

	// Pairwise duplicate check over the input assignments
	// Pairs pack row by row: ten pairs of five fields fill bits 9 to 0
	// Each pair owns one bit, so no bit has two drivers
	for (genvar i = 0; i < IN_ASSIGN_NUM; i++) begin : g_dupA
		for (genvar j = 0; j < IN_ASSIGN_NUM; j++) begin : g_dupB
			if (j > i) begin : g_pair
				logic [FN_W-1:0] fa, fb;
				assign fa = inAssign_ff[i*FN_W +: FN_W];
				assign fb = inAssign_ff[j*FN_W +: FN_W];
				assign dupHit[i*(2*IN_ASSIGN_NUM - i - 1)/2 + j - i - 1] = (fa == fb)
					&& (fa != FN_NONE)
					&& (fa != FN_FORCED_STOP);
			end
		end
	end

	// Raw detections, one bit per priority slot
	// Heat and supply faults arrive as comparator levels from the power stage
	// The diagnosis bit only means something in a frame cycle
	always_comb begin
		detect = 15'h0;
		detect[AL_OC1] = ocTrip1;
		detect[AL_OC2] = ocTrip2;
		detect[AL_OSPD] = speedScaled > limitScaled;
		detect[AL_OVOLT] = dcLinkVolts > OV_LIMIT_V;
		detect[AL_ENC] = encFrameValid & encDiagFault;
		detect[AL_CPWR] = ctrlPowerFault;
		detect[AL_MEM] = nvmCorrupt;
		detect[AL_RTR_HOT] = regenTrHot;
		detect[AL_ENC_LINK] = encIdle_ff >= 32'(ENC_LOSS_LIMIT);
		detect[AL_DUP] = |dupHit[9:0];
		detect[AL_OLOAD] = heat_ff >= OL_HEAT_LIMIT;
		detect[AL_UVOLT] = (uvSetting_ff == UV_ENABLE_VAL) && (dcLinkVolts < UV_LIMIT_V);
		detect[AL_RRES_HOT] = regenResHot;
		detect[AL_DEV] = devAbs > devWidth_ff;
		detect[AL_AMP_HOT] = ampHot;
	end

	assign dupHit[14:10] = 5'h0;

	// Encoder watchdog and thermal integrator
	// Watchdog saturates so a dead link never wraps back to quiet
	always_comb begin
		nxt_encIdle = encIdle_ff;
		if (encFrameValid) begin
			nxt_encIdle = 32'h0;
		end else if (encIdle_ff < 32'(ENC_LOSS_LIMIT)) begin
			nxt_encIdle = encIdle_ff + 32'h1;
		end
		// Heat rises with torque excess and leaks one count at or below the allowance
		// Adding stops at the limit, so cooldown after a trip stays short
		nxt_heat = heat_ff;
		if (trqAbs > allowTrq_ff) begin
			if (heat_ff < OL_HEAT_LIMIT) begin
				nxt_heat = heat_ff + 28'(trqAbs - allowTrq_ff);
			end
		end else if (heat_ff != 28'h0) begin
			nxt_heat = heat_ff - 28'h1;
		end
	end

	// Clear requests; the sequence input acts on its rising edge
	// A held level would keep wiping repeat faults, hence the edge
	always_comb begin
		nxt_seqReset = seqResetIn;
		clearReq = (seqResetIn & ~seqReset_ff)
			| (kpTestMode & kpAlarmClearFn);
	end

	// Latch; new detection beats a clear in the same cycle
	// Non-resettable group survives every clear until rstn
	always_comb begin
		nxt_alarm = alarm_ff;
		if (clearReq) begin
			nxt_alarm = alarm_ff & NO_RESET_MASK;
		end
		nxt_alarm = nxt_alarm | detect;
	end

	// Detection and latch flops
	// Power cycle is the only way out for the fatal group
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			encIdle_ff <= 32'h0;
			heat_ff <= 28'h0;
			seqReset_ff <= 1'b0;
			alarm_ff <= 15'h0;
		end else begin
			encIdle_ff <= nxt_encIdle;
			heat_ff <= nxt_heat;
			seqReset_ff <= nxt_seqReset;
			alarm_ff <= nxt_alarm;
		end
	end

	// Fixed priority pick over latched alarms
	// Built on the latched vector, so a brief fault keeps its code
	sam_prio_enc #(
		.N(NUM_ALARMS)
	) u_prio (
		.vec(alarm_ff),
		.code(winCode)
	);

	// Half-second blink timebase
	// Phase runs free across code changes; it restarts only when idle
	sam_blink_div #(
		.HALF_CYCLES(BLINK_CYCLES)
	) u_blink (
		.clk(clk),
		.rstn(rstn),
		.en(|alarm_ff),
		.tick(blinkTick)
	);

	// Display: lit at first detection, then toggles each tick
	// Code follows the winner one cycle after the latch
	always_comb begin
		nxt_dispCode = winCode;
		nxt_dispLit = dispLit_ff;
		if (alarm_ff == 15'h0) begin
			nxt_dispLit = 1'b0;
		end else if (dispCode_ff == 4'h0) begin
			nxt_dispLit = 1'b1;
		end else if (blinkTick) begin
			nxt_dispLit = ~dispLit_ff;
		end
	end

	// Drive state: coast group overrides a decel in progress
	// Leaving coast needs every alarm gone; decel ends on motor stop, a coast alarm or every alarm gone
	always_comb begin
		nxt_drv = drv_ff;
		case (drv_ff)
			DRV_RUN: begin
				if (|(alarm_ff & COAST_MASK)) begin
					nxt_drv = DRV_COAST;
				end else if (|(alarm_ff & DECEL_MASK)) begin
					nxt_drv = DRV_DECEL;
				end
			end
			DRV_DECEL: begin
				if (|(alarm_ff & COAST_MASK) || motorSpeed == 16'h0) begin
					nxt_drv = DRV_COAST;
				end else if (alarm_ff == 15'h0) begin
					nxt_drv = DRV_RUN;
				end
			end
			DRV_COAST: begin
				if (alarm_ff == 15'h0) begin
					nxt_drv = DRV_RUN;
				end
			end
			default: nxt_drv = DRV_COAST;
		endcase
	end

	// Display and drive flops
	// Reset shows a dark display and a free drive
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dispCode_ff <= 4'h0;
			dispLit_ff <= 1'b0;
			drv_ff <= DRV_RUN;
		end else begin
			dispCode_ff <= nxt_dispCode;
			dispLit_ff <= nxt_dispLit;
			drv_ff <= nxt_drv;
		end
	end

	// Any coast-group alarm cuts drive at once, even mid-decel
	assign coastHit = |(alarm_ff & COAST_MASK);
	// Decel keeps drive on for braking torque until the motor stops
	assign dispCode = dispCode_ff;
	assign dispLit = dispLit_ff;
	assign driveEnable = (drv_ff != DRV_COAST) && !coastHit;
	assign maxTorqueDecel = (drv_ff == DRV_DECEL) && !coastHit;
endmodule

// ---- design/sam_blink_div.sv ----
`timescale 1ns/1ps
module sam_blink_div #(
	parameter int HALF_CYCLES = 50000000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control and tick
	input wire logic en,
	output logic tick
);
	import sam_pkg::*;

	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;

	// Restart while idle so the first lit phase is full length
	always_comb begin
		nxt_cnt = cnt_ff;
		tick = 1'b0;
		if (!en) begin
			nxt_cnt = 32'h0;
		end else if (cnt_ff == 32'(HALF_CYCLES - 1)) begin
			nxt_cnt = 32'h0;
			tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 32'h1;
		end
	end

	// Counter register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= 32'h0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// ---- design/sam_pkg.sv ----
package sam_pkg;

	// Clock and timing
	localparam int CLK_FREQ_MHZ = 100;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_FREQ_MHZ;
	localparam int ENC_LOSS_US = 1000;
	localparam int ENC_LOSS_CYCLES = ENC_LOSS_US * CLK_FREQ_MHZ;

	// Alarm vector, bit index is priority minus one
	localparam int NUM_ALARMS = 15;
	localparam int AL_OC1 = 0;
	localparam int AL_OC2 = 1;
	localparam int AL_OSPD = 2;
	localparam int AL_OVOLT = 3;
	localparam int AL_ENC = 4;
	localparam int AL_CPWR = 5;
	localparam int AL_MEM = 6;
	localparam int AL_RTR_HOT = 7;
	localparam int AL_ENC_LINK = 8;
	localparam int AL_DUP = 9;
	localparam int AL_OLOAD = 10;
	localparam int AL_UVOLT = 11;
	localparam int AL_RRES_HOT = 12;
	localparam int AL_DEV = 13;
	localparam int AL_AMP_HOT = 14;
	localparam logic [14:0] COAST_MASK = 15'h03FF;
	localparam logic [14:0] DECEL_MASK = 15'h7C00;
	localparam logic [14:0] NO_RESET_MASK = 15'h0270;

	// Register map, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAX_SPEED = 8'h04;
	localparam logic [7:0] OFS_DEV_WIDTH = 8'h08;
	localparam logic [7:0] OFS_IN_ASSIGN = 8'h0C;
	localparam logic [7:0] OFS_ALLOW_TRQ = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_DISPLAY = 8'h18;

	// Field layouts and reset values
	localparam int IN_ASSIGN_NUM = 5;
	localparam int FN_W = 4;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] UV_ENABLE_VAL = 8'h01;
	localparam logic [15:0] MAX_SPEED_RST = 16'h1388;
	localparam logic [31:0] DEV_WIDTH_RST = 32'h0000_2710;
	localparam logic [19:0] IN_ASSIGN_RST = 20'h00000;
	localparam logic [15:0] ALLOW_TRQ_RST = 16'h0064;
	localparam logic [3:0] FN_NONE = 4'h0;
	localparam logic [3:0] FN_FORCED_STOP = 4'h7;

	// Detection thresholds
	localparam logic [9:0] OV_LIMIT_V = 10'h1A4;
	localparam logic [9:0] UV_LIMIT_V = 10'h0D2;
	localparam logic [3:0] OSPD_NUM = 4'hB;
	localparam logic [3:0] OSPD_DEN = 4'hA;
	localparam logic [27:0] OL_HEAT_LIMIT = 28'h0100000;

	// Drive state, Gray along run, decel, coast
	typedef enum logic [1:0] {
		DRV_RUN = 2'b00,
		DRV_DECEL = 2'b01,
		DRV_COAST = 2'b11
	} sam_drv_t;

endpackage

// ---- design/sam_prio_enc.sv ----
`timescale 1ns/1ps
module sam_prio_enc #(
	parameter int N = 15
) (
	// Latched alarm vector, bit 0 highest priority
	input wire logic [N-1:0] vec,
	// Winning code, zero when none
	output logic [3:0] code
);
	import sam_pkg::*;

	logic [N:0] anyBelow;
	logic [N-1:0] first;

	assign anyBelow[0] = 1'b0;

	// Lowest set bit wins
	for (genvar i = 0; i < N; i++) begin : g_pick
		assign first[i] = vec[i] & ~anyBelow[i];
		assign anyBelow[i+1] = anyBelow[i] | vec[i];
	end

	// One-hot to code
	always_comb begin
		code = 4'h0;
		for (int i = 0; i < N; i++) begin
			if (first[i]) begin
				code = code | 4'(i + 1);
			end
		end
	end
endmodule

// ---- tb/sam_alarm_manager_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errTotal++; \
	$display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module sam_alarm_manager_bench;
	import sam_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, cmdPos = 32'h0, fbPos = 32'h0, regRdata;
	logic ocTrip1 = 1'b0, ocTrip2 = 1'b0, ctrlPowerFault = 1'b0, nvmCorrupt = 1'b0;
	logic regenTrHot = 1'b0, regenResHot = 1'b0, ampHot = 1'b0, linkUp = 1'b1, selfFault = 1'b0;
	logic seqResetIn = 1'b0, kpTestMode = 1'b0, kpAlarmClearFn = 1'b0;
	logic [9:0] dcLinkVolts = 10'h12C;
	logic [15:0] motorSpeed = 16'h0, torqueCmd = 16'h0;
	logic encFrameValid, encDiagFault, dispLit, driveEnable, maxTorqueDecel;
	logic [3:0] dispCode;
	logic [7:0] adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
	logic [31:0] rst [8] = '{32'h0, 32'h1388, 32'h2710, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0};
	int errTotal = 0, totalChecks = 0;
	// Short blink and link-loss counts keep the run brief
	sam_alarm_manager #(.BLINK_CYCLES(8), .ENC_LOSS_LIMIT(20)) sam_alarm_manager_inst (.clk,
		.rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .ocTrip1, .ocTrip2, .dcLinkVolts,
		.ctrlPowerFault, .nvmCorrupt, .regenTrHot, .regenResHot, .ampHot, .motorSpeed, .cmdPos,
		.fbPos, .torqueCmd, .encFrameValid, .encDiagFault, .seqResetIn, .kpTestMode,
		.kpAlarmClearFn, .dispCode, .dispLit, .driveEnable, .maxTorqueDecel);
	sam_encoder_model sam_encoder_model_inst (.clk, .rstn, .linkUp, .selfFault,
		.frameValid(encFrameValid), .diagBit(encDiagFault));
	always #5 clk = ~clk;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bus cycles; an edge passes after each strobe drops
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`CHK(regRdata, e)
		@(posedge clk);
	endtask
	task automatic look(input logic [3:0] c, input logic d, input logic m);
		#1;
		`CHK(dispCode, c)
		`CHK(driveEnable, d)
		`CHK(maxTorqueDecel, m)
		@(posedge clk);
	endtask
	// Bounded wait for a display code
	task automatic waitc(input logic [3:0] c);
		for (int n = 0; n < 5000; n++) begin
			@(posedge clk);
			#1;
			if (dispCode === c) break;
		end
		`CHK(dispCode, c)
		@(posedge clk);
	endtask
	// Drive the cause of alarm bit i
	task automatic src(input int i, input logic v);
		case (i)
			0: ocTrip1 <= v;
			1: ocTrip2 <= v;
			2: motorSpeed <= v ? 16'h157D : 16'h0000;
			3: dcLinkVolts <= v ? 10'h1A5 : 10'h12C;
			4: selfFault <= v;
			5: ctrlPowerFault <= v;
			6: nvmCorrupt <= v;
			7: regenTrHot <= v;
			8: linkUp <= !v;
			9: wr(OFS_IN_ASSIGN, v ? 32'h11 : 32'h0);
			10: torqueCmd <= v ? 16'h0164 : 16'h0000;
			11: dcLinkVolts <= v ? 10'h0D1 : 10'h12C;
			12: regenResHot <= v;
			13: cmdPos <= v ? 32'h2711 : 32'h0;
			default: ampHot <= v;
		endcase
	endtask
	task automatic testDone();
		if (errTotal == 0 && totalChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Run needs about 7500 cycles, most of it the overload ramp
	initial begin
		#(20000 * 10);
		errTotal++;
		testDone();
	end
	initial begin
		tick(3);
		rstn <= 1'b1;
		@(posedge clk);
		// Reset values, read-only status, unmapped hole
		wr(OFS_STATUS, 32'h7FFF);
		for (int k = 0; k < 8; k++) rdc(adr[k], rst[k]);
		// Values just inside every threshold raise nothing
		motorSpeed <= 16'h157C;
		dcLinkVolts <= 10'h0D1;
		cmdPos <= 32'h2710;
		torqueCmd <= 16'h0064;
		wr(OFS_IN_ASSIGN, 32'h77);
		dcLinkVolts <= 10'h0D2;
		wr(OFS_CTRL, 32'h1);
		dcLinkVolts <= 10'h1A4;
		tick(4);
		rdc(OFS_STATUS, 32'h0);
		src(3, 1'b0);
		motorSpeed <= 16'h0064;
		cmdPos <= 32'h0;
		torqueCmd <= 16'h0;
		wr(OFS_IN_ASSIGN, 32'h0);
		// Decel group, then keypad clear outside and inside test mode
		src(14, 1'b1);
		tick(3);
		src(14, 1'b0);
		look(4'hF, 1'b1, 1'b1);
		motorSpeed <= 16'h0;
		tick(2);
		look(4'hF, 1'b0, 1'b0);
		kpAlarmClearFn <= 1'b1;
		tick(1);
		kpAlarmClearFn <= 1'b0;
		tick(2);
		look(4'hF, 1'b0, 1'b0);
		kpTestMode <= 1'b1;
		kpAlarmClearFn <= 1'b1;
		tick(1);
		kpAlarmClearFn <= 1'b0;
		tick(3);
		look(4'h0, 1'b1, 1'b0);
		// Rising priority, each new alarm takes the display
		for (int i = 14; i >= 0; i--) begin
			src(i, 1'b1);
			waitc(4'(i + 1));
			tick(4);
			src(i, 1'b0);
			rdc(OFS_STATUS, 32'h7FFF & ~((32'h1 << i) - 32'h1));
		end
		tick(3000);
		seqResetIn <= 1'b1;
		tick(3);
		seqResetIn <= 1'b0;
		rdc(OFS_STATUS, 32'h0270);
		look(4'h5, 1'b0, 1'b0);
		// Power cycle clears the rest
		rstn <= 1'b0;
		tick(2);
		rstn <= 1'b1;
		tick(3);
		rdc(OFS_STATUS, 32'h0);
		look(4'h0, 1'b1, 1'b0);
		testDone();
	end
endmodule

// ---- tb/sam_alarm_manager_checker.sv ----
`timescale 1ns/1ps
module sam_alarm_manager_checker #(
	parameter int BLINK_CYCLES = 8,
	parameter int ENC_LOSS_LIMIT = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched detections
	input wire logic ocTrip1,
	input wire logic ocTrip2,
	input wire logic ctrlPowerFault,
	input wire logic nvmCorrupt,
	input wire logic regenTrHot,
	input wire logic [15:0] motorSpeed,
	input wire logic encFrameValid,
	// Display and drive
	input wire logic [3:0] dispCode,
	input wire logic dispLit,
	input wire logic driveEnable,
	input wire logic maxTorqueDecel
);
	logic [7:0] litRun_ff;
	logic [7:0] gap_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Age of blink phase and of encoder silence; phase runs on across code changes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			litRun_ff <= 8'h00;
			gap_ff <= 8'h00;
		end else begin
			litRun_ff <= (dispCode == 4'h0 || $changed(dispLit)) ? 8'h00 : litRun_ff + 8'h01;
			gap_ff <= encFrameValid ? 8'h00 : gap_ff + 8'h01;
		end
	end
	a_coast_drop: assert property ((ocTrip1 || ocTrip2 || ctrlPowerFault || nvmCorrupt ||
		regenTrHot) |=> !driveEnable) else $error("drive kept after coast alarm");
	a_oc_code: assert property (ocTrip1 |-> ##2 dispCode == 4'h1)
		else $error("overcurrent code not shown");
	a_lit_first: assert property (dispCode == 4'h0 ##1 dispCode != 4'h0 |-> dispLit)
		else $error("new alarm not lit");
	a_blink_slow: assert property (dispCode != 4'h0 |-> litRun_ff <= BLINK_CYCLES + 2)
		else $error("blink too slow");
	a_blink_fast: assert property ($changed(dispLit) && dispCode != 4'h0 && $stable(dispCode)
		|-> litRun_ff >= BLINK_CYCLES - 3) else $error("blink too fast");
	a_decel_drive: assert property (maxTorqueDecel |-> driveEnable)
		else $error("drive removed during decel");
	a_decel_end: assert property (maxTorqueDecel && motorSpeed == 16'h0 |-> ##[1:2]
		!maxTorqueDecel) else $error("decel held after stop");
	a_fatal_hold: assert property (dispCode inside {4'h5, 4'h6, 4'h7, 4'hA} |=>
		dispCode != 4'h0 && !driveEnable) else $error("fatal alarm cleared");
	a_enc_loss: assert property (gap_ff > ENC_LOSS_LIMIT + 2 |-> !driveEnable)
		else $error("link loss not flagged");
endmodule

bind sam_alarm_manager sam_alarm_manager_checker #(
	.BLINK_CYCLES(BLINK_CYCLES),
	.ENC_LOSS_LIMIT(ENC_LOSS_LIMIT)
) sam_alarm_manager_checker_inst (.clk, .rstn, .ocTrip1, .ocTrip2, .ctrlPowerFault,
	.nvmCorrupt, .regenTrHot, .motorSpeed, .encFrameValid, .dispCode, .dispLit,
	.driveEnable, .maxTorqueDecel);

// ---- tb/sam_encoder_model.sv ----
`timescale 1ns/1ps
module sam_encoder_model #(
	parameter int PERIOD = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Scenario controls
	input wire logic linkUp,
	input wire logic selfFault,
	// Frames toward the amplifier
	output logic frameValid,
	output logic diagBit
);
	int cnt;
	// Frame every PERIOD cycles; diag line is junk between frames
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			frameValid <= 1'b0;
			diagBit <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			frameValid <= linkUp && cnt == 0;
			diagBit <= (linkUp && cnt == 0) ? selfFault : ~diagBit;
		end
	end
endmodule
